// ### logic/fbport_pad.sv
// Output driver selection for the five port pins.
`timescale 1ns/1ps
module fbport_pad #(
   parameter int WIDTH = 5 // Port width
) (
   input wire logic [WIDTH-1:0] latch, // Output latch
   input wire logic [WIDTH-1:0] dir, // Direction, one is input
   input wire logic [WIDTH-1:0] cmp_out_mask, // Comparator output select
   input wire logic [WIDTH-1:0] cmp_out, // Comparator output value
   output logic [WIDTH-1:0] pin_o, // Pin output value
   output logic [WIDTH-1:0] pin_oe // Pin output enable
);
   // ***************************************
   // Per-pin drivers
   // ***************************************
   // Push-pull on low bits; top bit open drain so only pulls low
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_pin
         logic val;
         assign val = cmp_out_mask[i] ? cmp_out[i] : latch[i]; // [RULE_13] [RULE_05]
         if (i == WIDTH - 1) begin : g_od
            assign pin_o[i] = 1'b0;
            assign pin_oe[i] = !dir[i] && !val; // [RULE_17] [RULE_02]
         end else begin : g_pp
            assign pin_o[i] = val;
            assign pin_oe[i] = !dir[i]; // [RULE_04] [RULE_02]
         end
      end
   endgenerate
endmodule // fbport_pad

// ### logic/fbport_params.svh
// Constants for the five-bit port: offsets, field positions, reset values.
// Notes on behaviour
// RULE_01 - Five port bits, each with its own output data latch.
// RULE_02 - Bit 4 has an open-drain output; bits 0 to 3 drive push-pull.
// RULE_03 - Bit 4 also feeds the timer external clock input.
// RULE_04 - A direction bit of one releases that pin's driver.
// RULE_05 - A direction bit of zero drives the pin from its latch.
// RULE_06 - Data reads return pin levels; data writes load the latch.
// RULE_07 - Writes sample the pins, merge the written bits, store the result.
// RULE_08 - Comparator and reference control bits select each pin's role.
// RULE_09 - Pins selected as comparator inputs read back as zero.
// RULE_10 - Reset makes every pin an input and disables digital input buffers.
// RULE_11 - Direction still applies to comparator pins; software keeps them inputs.
// RULE_12 - Bit 2 carries the reference output when enabled; software sets it input.
// RULE_13 - In one comparator mode bits 3 and 4 carry comparator outputs.
// RULE_14 - A pin owned by an enabled peripheral is not general purpose.
// RULE_15 - Comparator control value seven turns comparators off, pins become digital.
// RULE_16 - Upper three bits of direction and data read zero, writes ignored.
// RULE_17 - Open-drain pin pulls low only for latch zero and direction output.
`ifndef FBPORT_PARAMS_SVH
`define FBPORT_PARAMS_SVH
`define FBP_OFS_DATA 8'h00
`define FBP_OFS_DIR 8'h04
`define FBP_OFS_CMP 8'h08
`define FBP_OFS_VREF 8'h0c
`define FBP_OFS_CMPOUT 8'h10
`define FBP_DIR_RESET 5'h1f
`define FBP_DATA_RESET 5'h00
`define FBP_VREF_RESET 8'h00
`define FBP_DATA_WMASK 5'h1f
`define FBP_CMP_RESET 3'h0
`define FBP_CMP_OFF 3'h7
`define FBP_CMP_OUTMODE 3'h6
`define FBP_VREF_EN_BIT 7
`define FBP_VREF_OE_BIT 6
`endif

// ### logic/fbport_pinmux.sv
// Pin role selection from the comparator and reference controls.
`timescale 1ns/1ps
`include "fbport_params.svh"
module fbport_pinmux (
   input wire logic [2:0] cmp_mode, // Comparator mode
   input wire logic vref_out_en, // Reference drives bit 2
   output logic [4:0] analog_in_mask, // Pins used as comparator inputs
   output logic [4:0] cmp_out_mask // Pins carrying comparator outputs
);
   // ***************************************
   // Role decode
   // ***************************************
   // Value seven frees every pin except bit 2 while the reference is on; reset mode 0 grounds all analog inputs
   always_comb begin
      analog_in_mask = 5'h00;
      cmp_out_mask = 5'h00;
      case (cmp_mode)
         `FBP_CMP_OFF: analog_in_mask = 5'h00; // [RULE_15] [RULE_08]
         `FBP_CMP_OUTMODE: begin
            analog_in_mask = 5'h03; // Bits 0..1 stay analog
            cmp_out_mask = 5'h18; // [RULE_13]
         end
         3'h5: analog_in_mask = 5'h03;
         default: analog_in_mask = 5'h0f; // [RULE_10]
      endcase
      if (vref_out_en) begin
         analog_in_mask[2] = 1'b1; // [RULE_12] bit 2 owned by reference
      end
   end
endmodule // fbport_pinmux

// ### logic/fbport_pkg.sv
// Types shared by the five-bit port files.
package fbport_pkg;
   typedef enum logic [1:0] {
      FBP_ST_IDLE,
      FBP_ST_WRITE,
      FBP_ST_READ
   } fbport_bus_st_t;
   typedef logic [4:0] fbport_pins_t;
endpackage

// ### logic/fbport_top.sv
// Five-bit general purpose port with direction control on AHB-Lite.
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "fbport_params.svh"
module fbport_top (
   input wire logic CORE_CLK, // Core clock, 40 MHz
   input wire logic RESET_N, // Asynchronous reset, active low
   input wire logic HSEL, // Slave select
   input wire logic [31:0] HADDR, // Byte address
   input wire logic [1:0] HTRANS, // Transfer type
   input wire logic HWRITE, // Write when high
   input wire logic [2:0] HSIZE, // Transfer size
   input wire logic HREADY, // Bus ready in
   input wire logic [31:0] HWDATA, // Write data
   output logic [31:0] HRDATA, // Read data
   output logic HREADYOUT, // Slave ready
   output logic HRESP, // Response, always OKAY
   input wire logic [4:0] PORT_PIN_I, // Pin levels
   output logic [4:0] PORT_PIN_O, // Pin drive value
   output logic [4:0] PORT_PIN_OE, // Pin drive enable
   input wire logic [1:0] CMP_RESULT, // Comparator results
   output logic TIMER_EXT_CLK, // Timer external clock input
   output logic [4:0] ANALOG_IN_SEL, // Pins routed to comparator inputs
   output logic [2:0] CMP_MODE, // Comparator mode
   output logic VREF_PIN_EN // Reference driving bit 2 pin
);
   // ***************************************
   // Registers
   // ***************************************
   logic [4:0] port_a_data_q; // One output latch bit per pin [RULE_01]
   logic [4:0] port_a_direction_q;
   logic [2:0] comparator_control_q;
   logic [7:0] voltage_reference_control_q;
   logic [31:0] hrdata_q;
   logic [7:0] addr_q;
   fbport_pkg::fbport_bus_st_t st_q;
   logic [4:0] analog_in_mask;
   logic [4:0] cmp_out_mask;
   logic [4:0] pin_read;
   logic take;
   logic vref_on;

   // Read view of the port: analog pins read zero
   function automatic logic [31:0] fbp_read(input logic [7:0] a, input logic [4:0] pins,
                                            input logic [4:0] dir, input logic [2:0] cm,
                                            input logic [7:0] vr, input logic [1:0] co);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         `FBP_OFS_DATA: r = {27'h0, pins}; // [RULE_06] [RULE_16]
         `FBP_OFS_DIR: r = {27'h0, dir}; // [RULE_16]
         `FBP_OFS_CMP: r = {29'h0, cm};
         `FBP_OFS_VREF: r = {24'h0, vr};
         `FBP_OFS_CMPOUT: r = {30'h0, co};
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   assign vref_on = voltage_reference_control_q[`FBP_VREF_EN_BIT]
                    && voltage_reference_control_q[`FBP_VREF_OE_BIT];

   fbport_pinmux u_pinmux (
      .cmp_mode(comparator_control_q),
      .vref_out_en(vref_on),
      .analog_in_mask(analog_in_mask),
      .cmp_out_mask(cmp_out_mask)
   );

   fbport_pad #(.WIDTH(5)) u_pad (
      .latch(port_a_data_q),
      .dir(port_a_direction_q),
      .cmp_out_mask(cmp_out_mask),
      .cmp_out({CMP_RESULT[1], CMP_RESULT[0], 3'h0}),
      .pin_o(PORT_PIN_O),
      .pin_oe(PORT_PIN_OE)
   );

   // ***************************************
   // Pin sampling
   // ***************************************
   // Analog pins have their digital buffer off, so read zero
   assign pin_read = PORT_PIN_I & ~analog_in_mask; // [RULE_09] [RULE_10] [RULE_14]
   assign TIMER_EXT_CLK = PORT_PIN_I[4]; // [RULE_03]
   assign ANALOG_IN_SEL = analog_in_mask; // [RULE_08]
   assign CMP_MODE = comparator_control_q;
   assign VREF_PIN_EN = vref_on; // [RULE_12]

   // ***************************************
   // Bus slave
   // ***************************************
   assign take = HSEL && HREADY && HTRANS[1];
   assign HREADYOUT = 1'b1; // Zero wait states
   assign HRESP = 1'b0;
   assign HRDATA = hrdata_q;

   // Address phase capture
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_q <= fbport_pkg::FBP_ST_IDLE;
         addr_q <= 8'h00;
      end else begin
         case (st_q)
            fbport_pkg::FBP_ST_IDLE, fbport_pkg::FBP_ST_WRITE, fbport_pkg::FBP_ST_READ: begin
               if (take) begin
                  st_q <= HWRITE ? fbport_pkg::FBP_ST_WRITE : fbport_pkg::FBP_ST_READ;
                  addr_q <= {HADDR[7:2], 2'b00};
               end else begin
                  st_q <= fbport_pkg::FBP_ST_IDLE;
               end
            end
            default: st_q <= fbport_pkg::FBP_ST_IDLE;
         endcase
      end
   end

   // Read data registered at the address phase, valid in the data phase
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         hrdata_q <= 32'h0000_0000;
      end else if (take && !HWRITE) begin
         hrdata_q <= fbp_read({HADDR[7:2], 2'b00}, pin_read, port_a_direction_q,
                              comparator_control_q, voltage_reference_control_q,
                              CMP_RESULT);
      end
   end

   // Data latch: write is read-modify-write of the pins
   // A bus word covers every bit, so the merge mask is full and the latch takes the word
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         port_a_data_q <= `FBP_DATA_RESET;
      end else if (st_q == fbport_pkg::FBP_ST_WRITE && addr_q == `FBP_OFS_DATA) begin
         port_a_data_q <= (pin_read & ~`FBP_DATA_WMASK)
                          | (HWDATA[4:0] & `FBP_DATA_WMASK); // [RULE_07]
      end
   end

   // Direction register, all inputs at reset
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         port_a_direction_q <= `FBP_DIR_RESET; // [RULE_10]
      end else if (st_q == fbport_pkg::FBP_ST_WRITE && addr_q == `FBP_OFS_DIR) begin
         port_a_direction_q <= HWDATA[4:0]; // [RULE_04] [RULE_11] [RULE_16]
      end
   end

   // Comparator and reference controls
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         comparator_control_q <= `FBP_CMP_RESET;
         voltage_reference_control_q <= `FBP_VREF_RESET;
      end else if (st_q == fbport_pkg::FBP_ST_WRITE) begin
         if (addr_q == `FBP_OFS_CMP) begin
            comparator_control_q <= HWDATA[2:0]; // [RULE_15] [RULE_08]
         end
         if (addr_q == `FBP_OFS_VREF) begin
            voltage_reference_control_q <= HWDATA[7:0];
         end
      end
   end

   // ***************************************
   // Checks
   // ***************************************
   AST_RESET_INPUTS: assert property (@(posedge CORE_CLK)
      $rose(RESET_N) |-> port_a_direction_q == 5'h1f) // [RULE_10]
      else $error("direction not all inputs after reset");
   AST_DIR_HIZ: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      port_a_direction_q[1] |-> !PORT_PIN_OE[1]) // [RULE_04]
      else $error("input pin driven");
   AST_DIR_DRIVE: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      !port_a_direction_q[0] |-> PORT_PIN_OE[0] && PORT_PIN_O[0] == port_a_data_q[0]) // [RULE_05]
      else $error("output pin not driven from latch");
   AST_OPEN_DRAIN: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      PORT_PIN_O[4] == 1'b0 && (PORT_PIN_OE[4] ->
      !port_a_direction_q[4])) // [RULE_17]
      else $error("open drain pin drove high");
   AST_ANALOG_ZERO: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      take && !HWRITE && HADDR[7:0] == `FBP_OFS_DATA && analog_in_mask[0]
      ##1 HREADYOUT |-> HRDATA[0] == 1'b0) // [RULE_09]
      else $error("analog pin read nonzero");
   AST_READ_PINS: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      take && !HWRITE && HADDR[7:0] == `FBP_OFS_DATA |=>
      HRDATA[4:0] == $past(pin_read) && HRDATA[31:5] == 27'h0) // [RULE_06] [RULE_16]
      else $error("data read mismatch");
   AST_DIR_WRITE: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      st_q == fbport_pkg::FBP_ST_WRITE && addr_q == `FBP_OFS_DIR |=>
      port_a_direction_q == $past(HWDATA[4:0])) // [RULE_16]
      else $error("direction write lost");
   AST_CMP_OFF: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      comparator_control_q == `FBP_CMP_OFF && !vref_on |-> analog_in_mask == 5'h00) // [RULE_15]
      else $error("pins not released");
   AST_TIMER_CLK: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      TIMER_EXT_CLK == PORT_PIN_I[4]) // [RULE_03]
      else $error("timer clock not from bit 4");
   COV_WRITE_DATA: cover property (@(posedge CORE_CLK)
      st_q == fbport_pkg::FBP_ST_WRITE && addr_q == `FBP_OFS_DATA);
   COV_CMP_OUT: cover property (@(posedge CORE_CLK) cmp_out_mask[3] && PORT_PIN_OE[3]);
   COV_VREF: cover property (@(posedge CORE_CLK) vref_on);
endmodule // fbport_top

// ### verification/fbport_pin_far.sv
// Far-side circuitry model for the five port pins.
`timescale 1ns/1ps
module fbport_pin_far (
   input wire logic clk, // Core clock
   input wire logic [4:0] pin_o, // Device drive value
   input wire logic [4:0] pin_oe, // Device drive enable
   input wire logic [4:0] ext_val, // External driver value
   input wire logic [4:0] ext_en, // External driver enable
   output logic [4:0] pin_lvl // Resolved pin levels
);
   // **********
   // Pin levels
   // **********
   logic [4:0] idle_q = 5'h0a;
   // Floating pins wander so a stale value is never read as real
   always_ff @(posedge clk) begin
      idle_q <= ~idle_q;
   end
   // Push-pull pins follow whoever drives; bit 4 is a wired-AND with a pull-up, high unless pulled low
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_lvl[i] = pin_oe[i] ? pin_o[i] : (ext_en[i] ? ext_val[i] : idle_q[i]);
      end
      pin_lvl[4] = !pin_oe[4] && !(ext_en[4] && !ext_val[4]);
   end
endmodule // fbport_pin_far

// ### verification/test_five_bit_port_with_direction.sv
// Self-checking bench for the five-bit port.
`timescale 1ns/1ps
`include "fbport_params.svh"
module test_five_bit_port_with_direction;
   // ***************
   // Signals, model
   // ***************
   logic core_clk;
   logic reset_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] cmp_res = 2'h0;
   logic [4:0] ext_val = 5'h0;
   logic [4:0] ext_en = 5'h1f;
   logic [31:0] seed = 32'hb4c7c524;
   logic [31:0] hrdata, q, m_lat, m_dir, m_cm, m_vr;
   logic hrdy, hresp, tmr_clk, vref_en;
   logic [4:0] pin_i, pin_o, pin_oe, an_sel;
   logic [2:0] cmp_mode;
   int failures = 0;
   int cmp_count = 0;
   fbport_top DUT (.CORE_CLK(core_clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hrdy), .HWDATA(hwdata),
      .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .PORT_PIN_I(pin_i),
      .PORT_PIN_O(pin_o), .PORT_PIN_OE(pin_oe), .CMP_RESULT(cmp_res),
      .TIMER_EXT_CLK(tmr_clk), .ANALOG_IN_SEL(an_sel), .CMP_MODE(cmp_mode),
      .VREF_PIN_EN(vref_en));
   fbport_pin_far FAR (.clk(core_clk), .pin_o(pin_o), .pin_oe(pin_oe), .ext_val(ext_val),
      .ext_en(ext_en), .pin_lvl(pin_i));
   // 40 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // ***************
   // Helpers
   // ***************
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [4:0] drv();
      drv = m_lat[4:0];
      if (m_cm == 6) begin
         drv[4:3] = cmp_res;
      end
   endfunction
   function automatic logic [4:0] oe();
      logic [4:0] d;
      d = drv();
      oe = ~m_dir[4:0];
      oe[4] = !m_dir[4] && !d[4];
   endfunction
   // Analog pins per mode; reference needs both enable and output bits
   function automatic logic [4:0] amask();
      amask = (m_cm == 7) ? 5'h00 : (m_cm >= 5) ? 5'h03 : 5'h0f;
      if (m_vr[7:6] == 2'h3) amask[2] = 1'b1;
   endfunction
   function automatic logic [4:0] lvl();
      logic [4:0] e;
      e = oe();
      lvl = (e & drv()) | (~e & ext_val);
      lvl[4] = !e[4] && !(ext_en[4] && !ext_val[4]);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t: %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   task automatic chk_pins();
      chk(pin_oe, oe(), "drive enable");
      chk(pin_o & pin_oe, drv() & oe(), "drive value");
      chk(pin_o[4], 1'b0, "open drain");
      chk(an_sel, amask(), "analog select");
      chk(cmp_mode, m_cm, "comparator mode");
      chk(vref_en, m_vr[7] & m_vr[6], "reference pin");
      chk(tmr_clk, pin_i[4], "timer clock");
      chk(hresp, 1'b0, "response");
   endtask
   // One single AHB transfer; waits are bounded
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do begin @(posedge core_clk); n++; end while (hrdy !== 1'b1 && n < 32);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge core_clk); n++; end while (hrdy !== 1'b1 && n < 64);
      q = hrdata;
      if (hrdy !== 1'b1) begin
         failures++;
         $display("FAIL %0t: bus wait expired", $time);
      end
   endtask
   task automatic set_ext(input logic [4:0] v);
      ext_val <= v;
      ext_en <= m_dir[4:0] | 5'h10; // Outside drives input pins only; bit 4 may always pull low
      @(posedge core_clk);
      #1;
      chk_pins();
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
      case (a)
         `FBP_OFS_DATA: m_lat = d & 32'h1f;
         `FBP_OFS_DIR: m_dir = d & 32'h1f;
         `FBP_OFS_CMP: m_cm = d & 32'h7;
         `FBP_OFS_VREF: m_vr = d & 32'hff;
         default: ;
      endcase
      set_ext(ext_val);
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      chk(q, e, "read");
   endtask
   task automatic mreset();
      m_lat = 32'h0;
      m_dir = 32'h1f;
      m_cm = 32'h0;
      m_vr = 32'h0;
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ***************
   // Tests
   // ***************
   initial begin
      mreset();
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      set_ext(5'(rnd()));
      rd_chk(`FBP_OFS_DIR, 32'h1f);
      rd_chk(`FBP_OFS_CMP, 32'h0);
      rd_chk(`FBP_OFS_DATA, {27'h0, lvl() & ~amask()});
      $display("reset test done");
      wr(`FBP_OFS_DIR, 32'h1f);
      for (int m = 0; m < 16; m++) begin
         wr(`FBP_OFS_CMP, m & 7);
         wr(`FBP_OFS_VREF, m[3] ? 32'hc0 : 32'h40);
         set_ext(5'(rnd()));
         rd_chk(`FBP_OFS_DATA, {27'h0, lvl() & ~amask()});
         rd_chk(`FBP_OFS_VREF, m_vr);
      end
      $display("mode test done");
      wr(`FBP_OFS_CMP, 32'h7);
      wr(`FBP_OFS_VREF, 32'h0);
      for (int n = 0; n < 24; n++) begin
         wr(`FBP_OFS_DIR, rnd());
         wr(`FBP_OFS_DATA, rnd());
         set_ext(5'(rnd()));
         rd_chk(`FBP_OFS_DATA, {27'h0, lvl()});
         rd_chk(`FBP_OFS_DIR, m_dir);
      end
      $display("digital test done");
      wr(`FBP_OFS_CMP, 32'h6);
      wr(`FBP_OFS_DIR, 32'h07);
      for (int r = 0; r < 4; r++) begin
         cmp_res <= r[1:0];
         set_ext(5'(rnd()));
         rd_chk(`FBP_OFS_CMPOUT, r);
         rd_chk(`FBP_OFS_DATA, {27'h0, lvl() & ~amask()});
      end
      $display("comparator output test done");
      wr(32'h20, 32'hffffffff);
      rd_chk(32'h20, 32'h0);
      rd_chk(`FBP_OFS_DIR, m_dir);
      $display("unmapped test done");
      reset_n <= 1'b0;
      mreset();
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      set_ext(5'(rnd()));
      rd_chk(`FBP_OFS_DIR, 32'h1f);
      $display("second reset test done");
      complete_run();
   end
   // Hang guard, far beyond the expected run
   initial begin
      #200000;
      failures++;
      $display("FAIL %0t: watchdog expired", $time);
      complete_run();
   end
endmodule // test_five_bit_port_with_direction
